// ---- core_timing_map.svh ----
// timing counts and widths for the core memory cycle controller
`ifndef CORE_TIMING_MAP_SVH
`define CORE_TIMING_MAP_SVH

`define CLK_PERIOD_NS       4
`define ADDR_WIDTH          12
`define DATA_WIDTH          17
`define TIMER_WIDTH         8

// nominal times in ns, rounded up to whole cycles
`define ADDR_SETUP_NS       20
`define EARLY_TO_LATE_NS    60
`define READ_WIDTH_NS       300
`define READ_TO_INHIBIT_NS  120
`define INHIBIT_TO_WRITE_NS 60
`define WRITE_WIDTH_NS      420
`define WRITE_TO_END_NS     60

`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define ADDR_SETUP_CYC      `NS_TO_CYC(`ADDR_SETUP_NS)
`define EARLY_TO_LATE_CYC   `NS_TO_CYC(`EARLY_TO_LATE_NS)
`define LATE_TO_RISE_CYC    `NS_TO_CYC(`READ_WIDTH_NS - `EARLY_TO_LATE_NS)
`define READ_TO_INHIBIT_CYC `NS_TO_CYC(`READ_TO_INHIBIT_NS)
`define INHIBIT_TO_WRITE_CYC `NS_TO_CYC(`INHIBIT_TO_WRITE_NS)
`define WRITE_WIDTH_CYC     `NS_TO_CYC(`WRITE_WIDTH_NS)
`define WRITE_TO_END_CYC    `NS_TO_CYC(`WRITE_TO_END_NS)

`endif

// ---- core_timing_pkg.sv ----
// types for the core memory cycle controller
`include "core_timing_map.svh"
package core_timing_pkg;

  typedef enum logic {
    OP_READ_RESTORE,
    OP_ERASE_WRITE
  } cycle_op_t;

  typedef struct packed {
    cycle_op_t                  op;
    logic [`ADDR_WIDTH-1:0]     addr;
    logic [`DATA_WIDTH-1:0]     wdata;
  } cycle_req_t;

  typedef struct packed {
    logic early_read_strobe_n;
    logic late_read_strobe_n;
    logic inhibit_strobe_n;
    logic write_drive_strobe_n;
  } strobes_t;

  typedef enum {
    ST_IDLE,
    ST_SETUP,
    ST_EARLY,
    ST_LATE,
    ST_GAP,
    ST_INHIBIT,
    ST_WRITE,
    ST_TAIL
  } cycle_state_t;

endpackage

// ---- interval_timer.sv ----
// down counter that times one phase of the memory cycle
`timescale 1ns/100ps
`include "core_timing_map.svh"
module interval_timer #(
  parameter int WIDTH = `TIMER_WIDTH
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  expired
);

  logic [WIDTH-1:0] count_r;

  // --------------------------------------------------------------
  // counter
  // --------------------------------------------------------------
  // load with phase length minus one, count down to zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count_r <= '0;
    end
    else if (load)
    begin
      count_r <= load_value;
    end
    else if (count_r != '0)
    begin
      count_r <= count_r - 1'b1;
    end
  end

  assign expired = (count_r == '0);

endmodule

// ---- core_cycle_ctrl.sv ----
// controller that runs read-restore and erase-write cycles on a core memory board
// Operation
// - address settles before early read falls; that edge is time zero
// - late read falls 60 ns after early read
// - both read strobes rise together at 300 ns
// - inhibit falls 120 ns after read strobes rise
// - write drive falls 60 ns after inhibit falls
// - write drive rises 60 ns before inhibit rises, ending the cycle
// - write data lines are active low: high stores zero, low stores one
// - all widths and spacings within plus or minus 9 ns of nominal
// - top three address lines select one of eight boards; no board select here, all twelve lines address the one 4096-word model board
`timescale 1ns/100ps
`include "core_timing_map.svh"
module core_cycle_ctrl #(
  parameter int ADDR_W = `ADDR_WIDTH,
  parameter int DATA_W = `DATA_WIDTH
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  // user side
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire core_timing_pkg::cycle_req_t req,
  output logic                            done,
  output logic [DATA_W-1:0]               read_data,
  output logic                            parity_fitted,
  // memory board pins
  output logic [ADDR_W-1:0]               word_address_lines,
  output logic                            early_read_strobe_n,
  output logic                            late_read_strobe_n,
  output logic                            inhibit_strobe_n,
  output logic                            write_drive_strobe_n,
  output logic [DATA_W-1:0]               write_data_lines,
  input  wire logic [DATA_W-1:0]          sense_output_bus,
  input  wire logic                       parity_present_n
);

  localparam int TW = `TIMER_WIDTH;

  core_timing_pkg::cycle_state_t state_r;
  core_timing_pkg::cycle_state_t state_nxt;
  core_timing_pkg::strobes_t     strobes_r;
  core_timing_pkg::strobes_t     strobes_nxt;
  core_timing_pkg::cycle_op_t    op_r;
  logic [DATA_W-1:0]             data_r;
  logic [DATA_W-1:0]             sense_meta_r;
  logic [DATA_W-1:0]             sense_sync_r;
  logic                          parity_meta_r;
  logic                          parity_sync_r;
  logic                          timer_load;
  logic [TW-1:0]                 timer_value;
  logic                          expired;
  logic                          done_r;
  logic                          parity_fitted_r;

  // phase length in cycles as a timer load value
  function automatic logic [TW-1:0] phase_len(input int cycles);
    phase_len = TW'(cycles - 1);
  endfunction

  // strobe levels for a given state, all high when idle
  function automatic core_timing_pkg::strobes_t strobes_for(input core_timing_pkg::cycle_state_t st);
    core_timing_pkg::strobes_t s;
    s = '{1'b1, 1'b1, 1'b1, 1'b1};
    unique case (st)
      core_timing_pkg::ST_IDLE, core_timing_pkg::ST_SETUP, core_timing_pkg::ST_GAP: ;
      core_timing_pkg::ST_EARLY:   s.early_read_strobe_n = 1'b0;
      core_timing_pkg::ST_LATE:
      begin
        s.early_read_strobe_n = 1'b0;
        s.late_read_strobe_n  = 1'b0;
      end
      core_timing_pkg::ST_INHIBIT, core_timing_pkg::ST_TAIL: s.inhibit_strobe_n = 1'b0;
      core_timing_pkg::ST_WRITE:
      begin
        s.inhibit_strobe_n     = 1'b0;
        s.write_drive_strobe_n = 1'b0;
      end
    endcase
    return s;
  endfunction

  // --------------------------------------------------------------
  // pin input synchronisers
  // --------------------------------------------------------------
  // sense bus and parity level come from the board, two flops each
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sense_meta_r  <= '0;
      sense_sync_r  <= '0;
      parity_meta_r <= 1'b1;
      parity_sync_r <= 1'b1;
    end
    else
    begin
      sense_meta_r  <= sense_output_bus;
      sense_sync_r  <= sense_meta_r;
      parity_meta_r <= parity_present_n;
      parity_sync_r <= parity_meta_r;
    end
  end

  // --------------------------------------------------------------
  // phase sequencing
  // --------------------------------------------------------------
  interval_timer #(
    .WIDTH      (TW)
  ) u_timer (
    .clock      (clock),
    .rst        (rst),
    .load       (timer_load),
    .load_value (timer_value),
    .expired    (expired)
  );

  // next phase and its length; every phase edge is timed from the last
  always_comb
  begin
    state_nxt   = state_r;
    timer_load  = 1'b0;
    timer_value = '0;
    unique case (state_r)
      core_timing_pkg::ST_IDLE:
        if (req_valid)
        begin
          state_nxt   = core_timing_pkg::ST_SETUP;
          timer_load  = 1'b1;
          timer_value = phase_len(`ADDR_SETUP_CYC);
        end
      core_timing_pkg::ST_SETUP:
        if (expired)
        begin
          state_nxt   = core_timing_pkg::ST_EARLY;
          timer_load  = 1'b1;
          timer_value = phase_len(`EARLY_TO_LATE_CYC);
        end
      core_timing_pkg::ST_EARLY:
        if (expired)
        begin
          state_nxt   = core_timing_pkg::ST_LATE;
          timer_load  = 1'b1;
          timer_value = phase_len(`LATE_TO_RISE_CYC);
        end
      core_timing_pkg::ST_LATE:
        if (expired)
        begin
          state_nxt   = core_timing_pkg::ST_GAP;
          timer_load  = 1'b1;
          timer_value = phase_len(`READ_TO_INHIBIT_CYC);
        end
      core_timing_pkg::ST_GAP:
        if (expired)
        begin
          state_nxt   = core_timing_pkg::ST_INHIBIT;
          timer_load  = 1'b1;
          timer_value = phase_len(`INHIBIT_TO_WRITE_CYC);
        end
      core_timing_pkg::ST_INHIBIT:
        if (expired)
        begin
          state_nxt   = core_timing_pkg::ST_WRITE;
          timer_load  = 1'b1;
          timer_value = phase_len(`WRITE_WIDTH_CYC);
        end
      core_timing_pkg::ST_WRITE:
        if (expired)
        begin
          state_nxt   = core_timing_pkg::ST_TAIL;
          timer_load  = 1'b1;
          timer_value = phase_len(`WRITE_TO_END_CYC);
        end
      core_timing_pkg::ST_TAIL:
        if (expired)
        begin
          state_nxt = core_timing_pkg::ST_IDLE;
        end
    endcase
  end

  assign strobes_nxt = strobes_for(state_nxt);

  // state and strobe registers; strobes change on the edge that enters a phase
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_r   <= core_timing_pkg::ST_IDLE;
      strobes_r <= '{1'b1, 1'b1, 1'b1, 1'b1};
    end
    else
    begin
      state_r   <= state_nxt;
      strobes_r <= strobes_nxt; // both read strobes rise on one edge
    end
  end

  // --------------------------------------------------------------
  // address and data
  // --------------------------------------------------------------
  // address held from acceptance to the end of the cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      word_address_lines <= '0;
      op_r               <= core_timing_pkg::OP_READ_RESTORE;
    end
    else if (state_r == core_timing_pkg::ST_IDLE && req_valid)
    begin
      word_address_lines <= req.addr;
      op_r               <= req.op;
    end
  end

  // write data: new word for erase-write, sensed word for read-restore
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      data_r <= '0;
    end
    else if (state_r == core_timing_pkg::ST_IDLE && req_valid)
    begin
      data_r <= req.wdata;
    end
    else if (state_r == core_timing_pkg::ST_LATE && expired)
    begin
      if (op_r == core_timing_pkg::OP_READ_RESTORE)
      begin
        data_r <= sense_sync_r;
      end
    end
  end

  // sensed word and parity level captured as the read strobes rise
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      read_data       <= '0;
      parity_fitted_r <= 1'b0;
    end
    else if (state_r == core_timing_pkg::ST_LATE && expired)
    begin
      read_data       <= sense_sync_r;
      parity_fitted_r <= ~parity_sync_r;
    end
  end

  // one-cycle completion pulse as inhibit rises
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= (state_r == core_timing_pkg::ST_TAIL) && expired;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign write_data_lines     = ~data_r; // low stores a one
  assign early_read_strobe_n  = strobes_r.early_read_strobe_n;
  assign late_read_strobe_n   = strobes_r.late_read_strobe_n;
  assign inhibit_strobe_n     = strobes_r.inhibit_strobe_n;
  assign write_drive_strobe_n = strobes_r.write_drive_strobe_n;
  assign req_ready            = (state_r == core_timing_pkg::ST_IDLE);
  assign done                 = done_r;
  assign parity_fitted        = parity_fitted_r;

endmodule

// ---- core_mem_model.sv ----
// behavioural core memory board facing the cycle controller
`timescale 1ns/100ps
module core_mem_model #(
  parameter int PARITY = 1
) (
  input  wire logic [11:0] word_address_lines,
  input  wire logic        early_read_strobe_n,
  input  wire logic        late_read_strobe_n,
  input  wire logic        inhibit_strobe_n,
  input  wire logic        write_drive_strobe_n,
  input  wire logic [16:0] write_data_lines,
  input  wire logic        drive_current_gate,
  output logic      [16:0] sense_output_bus,
  output logic             parity_present_n
);
  // ----------------------------------------
  // core array and read / write phases
  // ----------------------------------------
  logic [16:0] mem [4096];
  logic [16:0] mask;
  logic        reading;

  assign mask = (PARITY == 1) ? 17'h1ffff : 17'h0ffff;
  assign parity_present_n = (PARITY == 1) ? 1'b0 : 1'b1;

  // start erased, sense bus released with a pattern
  initial
  begin
    foreach (mem[i]) mem[i] = 17'h00000;
    sense_output_bus = 17'h0aaaa;
    reading = 1'b0;
  end

  // both read drives on: addressed word shows on the sense bus
  always @(negedge late_read_strobe_n)
  begin
    if (early_read_strobe_n === 1'b0 && drive_current_gate === 1'b1)
    begin
      sense_output_bus = mem[word_address_lines] & mask;
      reading = 1'b1;
    end
  end

  // read end: word left at zero, nothing restored, sense bus inverted
  always @(posedge early_read_strobe_n)
  begin
    if (reading)
    begin
      mem[word_address_lines] = 17'h00000;
      sense_output_bus = ~sense_output_bus;
      reading = 1'b0;
    end
  end

  // write end: low data line stores one, inhibited bits stay zero
  always @(posedge write_drive_strobe_n)
  begin
    if (inhibit_strobe_n === 1'b0 && drive_current_gate === 1'b1)
      mem[word_address_lines] = ~write_data_lines & mask;
  end
endmodule

// ---- core_cycle_checker.sv ----
// concurrent checks on the core memory cycle controller ports
`timescale 1ns/100ps
module core_cycle_checker #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 17
) (
  input wire logic                        clock,
  input wire logic                        rst,
  input wire logic                        req_valid,
  input wire logic                        req_ready,
  input wire core_timing_pkg::cycle_req_t req,
  input wire logic                        done,
  input wire logic [DATA_W-1:0]           read_data,
  input wire logic                        parity_fitted,
  input wire logic [ADDR_W-1:0]           word_address_lines,
  input wire logic                        early_read_strobe_n,
  input wire logic                        late_read_strobe_n,
  input wire logic                        inhibit_strobe_n,
  input wire logic                        write_drive_strobe_n,
  input wire logic [DATA_W-1:0]           write_data_lines,
  input wire logic [DATA_W-1:0]           sense_output_bus,
  input wire logic                        parity_present_n
);
  // ----------------------------------------
  // strobe timing, 4 ns per cycle
  // ----------------------------------------
  logic accept;
  assign accept = req_valid && req_ready;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  addr_setup_a: assert property (accept |-> ##6 $fell(early_read_strobe_n))
    else $error("early read did not fall after address setup");
  late_delay_a: assert property ($fell(early_read_strobe_n) |-> ##15 $fell(late_read_strobe_n))
    else $error("late read not 60 ns after early read");
  read_width_a: assert property ($fell(early_read_strobe_n) |-> ##75 ($rose(early_read_strobe_n) && $rose(late_read_strobe_n)))
    else $error("read strobes not raised together at 300 ns");
  inhibit_delay_a: assert property ($rose(early_read_strobe_n) |-> inhibit_strobe_n[*8] ##23 $fell(inhibit_strobe_n))
    else $error("inhibit not 120 ns after read strobes rise");
  write_delay_a: assert property ($fell(inhibit_strobe_n) |-> ##15 $fell(write_drive_strobe_n))
    else $error("write drive not 60 ns after inhibit");
  write_lead_a: assert property ($rose(write_drive_strobe_n) |-> ##15 $rose(inhibit_strobe_n))
    else $error("write drive not raised 60 ns before inhibit");
  write_width_a: assert property ($fell(write_drive_strobe_n) |-> ##105 $rose(write_drive_strobe_n))
    else $error("write drive width off nominal");
  data_polarity_a: assert property (accept && req.op == core_timing_pkg::OP_ERASE_WRITE |=> write_data_lines == ~$past(req.wdata))
    else $error("write data lines not inverted");
  addr_stable_a: assert property (!early_read_strobe_n || !inhibit_strobe_n |-> $stable(word_address_lines))
    else $error("address moved during cycle");
  data_held_a: assert property (!inhibit_strobe_n |-> $stable(write_data_lines))
    else $error("write data moved during write phase");

  erase_cover: cover property (accept && req.op == core_timing_pkg::OP_ERASE_WRITE);
  restore_cover: cover property (accept && req.op == core_timing_pkg::OP_READ_RESTORE);
  done_cover: cover property (done);
endmodule

bind core_cycle_ctrl core_cycle_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_core_cycle_checker (
  .clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done),
  .read_data(read_data), .parity_fitted(parity_fitted), .word_address_lines(word_address_lines),
  .early_read_strobe_n(early_read_strobe_n), .late_read_strobe_n(late_read_strobe_n),
  .inhibit_strobe_n(inhibit_strobe_n), .write_drive_strobe_n(write_drive_strobe_n),
  .write_data_lines(write_data_lines), .sense_output_bus(sense_output_bus),
  .parity_present_n(parity_present_n));

// ---- tb.sv ----
// self-checking bench for the core memory cycle controller
`timescale 1ns/100ps
module tb;
  // ----------------------------------------
  // signals, instances, reference memory
  // ----------------------------------------
  logic                        clock, rst, req_valid, req_ready, done, parity_fitted, parity_present_n;
  logic                        early_read_strobe_n, late_read_strobe_n, inhibit_strobe_n, write_drive_strobe_n;
  core_timing_pkg::cycle_req_t req;
  logic [16:0]                 read_data, write_data_lines, sense_output_bus;
  logic [11:0]                 word_address_lines;
  int                          bad_count, checks_done, seed;
  logic                        gate_on;
  int                          ref_mem [int];
  logic [11:0]                 pool [6] = '{12'h000, 12'hfff, 12'h001, 12'h800, 12'h7ff, 12'h123};

  core_cycle_ctrl u_core_cycle_ctrl (
    .clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done),
    .read_data(read_data), .parity_fitted(parity_fitted), .word_address_lines(word_address_lines),
    .early_read_strobe_n(early_read_strobe_n), .late_read_strobe_n(late_read_strobe_n),
    .inhibit_strobe_n(inhibit_strobe_n), .write_drive_strobe_n(write_drive_strobe_n),
    .write_data_lines(write_data_lines), .sense_output_bus(sense_output_bus),
    .parity_present_n(parity_present_n));

  core_mem_model u_core_mem_model (
    .word_address_lines(word_address_lines), .early_read_strobe_n(early_read_strobe_n),
    .late_read_strobe_n(late_read_strobe_n), .inhibit_strobe_n(inhibit_strobe_n),
    .write_drive_strobe_n(write_drive_strobe_n), .write_data_lines(write_data_lines),
    .drive_current_gate(gate_on),
    .sense_output_bus(sense_output_bus), .parity_present_n(parity_present_n));

  // 250 MHz clock
  always #2 clock = ~clock;

  task compare(input string name, input logic [16:0] exp, input logic [16:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one full memory cycle, checked against the reference memory
  task run_cycle(input logic op, input logic [11:0] a, input logic [16:0] d);
    int          n;
    logic [16:0] exp;
    n = 0;
    exp = ref_mem.exists(a) ? ref_mem[a][16:0] : 17'h00000;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{op: core_timing_pkg::cycle_op_t'(op), addr: a, wdata: d};
    @(posedge clock);
    req_valid <= 1'b0;
    @(negedge clock);
    compare("req_ready_busy", 17'h00000, {16'h0000, req_ready});
    while (done !== 1'b1 && n < 400)
    begin
      @(negedge clock);
      n++;
    end
    compare("done", 17'h00001, {16'h0000, done});
    compare("req_ready", 17'h00001, {16'h0000, req_ready});
    if (gate_on)
      compare("read_data", exp, read_data);
    compare("parity_fitted", 17'h00001, {16'h0000, parity_fitted});
    // drive currents suppressed: the stored word must survive untouched
    if (op && gate_on)
      ref_mem[a] = int'(d);
    @(posedge clock);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    seed = 81266;
    gate_on = 1'b1;
    bad_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    run_cycle(1'b0, 12'h000, 17'h00000);
    run_cycle(1'b1, 12'h000, 17'h1ffff);
    run_cycle(1'b0, 12'h000, 17'h00000);
    run_cycle(1'b0, 12'h000, 17'h00000);
    run_cycle(1'b1, 12'hfff, 17'h0a5a5);
    run_cycle(1'b1, 12'hfff, 17'h10001);
    run_cycle(1'b0, 12'hfff, 17'h00000);
    gate_on = 1'b0;
    run_cycle(1'b1, 12'hfff, 17'h00f0f);
    gate_on = 1'b1;
    run_cycle(1'b0, 12'hfff, 17'h00000);
    for (int i = 0; i < 30; i++)
      run_cycle(1'($random(seed)), pool[$unsigned($random(seed)) % 6], 17'($random(seed)));
    summarize;
  end

  initial
  begin
    #200000;
    bad_count++;
    summarize;
  end
endmodule
